/* pmbus_handler_pkg.sv */
// constants, command codes and defaults for the power-module command-data handler
//
// Summary of operation
// (RULE_01) output voltage words: unsigned 16-bit mantissa, value is mantissa over 4096
// (RULE_02) other words: top five bits signed exponent, low eleven bits signed mantissa
// (RULE_03) every two-byte word travels low byte first, then high byte
// (RULE_04) write protection on after power-up; command 0xD0 turns it off or on
// (RULE_05) command 0x11 copies all current settings into non-volatile memory
// (RULE_06) operation bit 7 enables output when set; default one
// (RULE_07) on/off config bit 3 clear means pin only; set means operation bit honoured
// (RULE_08) all on/off config bits except bit 3 always read as one
// (RULE_09) output on only while pin active, and operation bit 7 too when bit 3 set
// (RULE_10) input on/off thresholds use exponent -3, mantissa sign zero, storable
// (RULE_11) host keeps turn-on threshold at least 2 V above turn-off threshold
// (RULE_12) turn-on delay accepts 10 to 500 ms in 0.5 ms steps
// (RULE_13) rise time accepts 15 to 500 ms; both use exponent -1, positive, storable
// (RULE_14) output setpoint limited to 8.10 V through 13.20 V, step 2^-12 V
// (RULE_15) operation bits 5:2 pick nominal, margin low 0110 or margin high 1010
// (RULE_16) output voltage readback is unsigned mantissa with exponent -12
// (RULE_17) signed factory offset added to raw output voltage; offset readable
// (RULE_18) input voltage readback uses exponent -3, mantissa sign forced zero
// (RULE_19) input reading is raw times gain over 8192 plus offset in 125 mV steps
// (RULE_20) output current readback exponent -3, non-negative; below 20 A reads zero
// (RULE_21) output current reads zero while converter sinks current
// (RULE_22) current reading is raw times gain over 8192 plus offset in 125 mA steps
// (RULE_23) packet error code checked when supplied, appended to every response
// (RULE_24) bus clock stretch never longer than 35 ms
// (RULE_25) out-of-range or write-protected setting writes are dropped, values unchanged
package pmbus_handler_pkg;

	// command codes
	localparam logic [7:0] CMD_OPERATION     = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] CMD_STORE_ALL     = 8'h11;
	localparam logic [7:0] CMD_VOUT_SET      = 8'h21;
	localparam logic [7:0] CMD_MARGIN_HIGH   = 8'h25;
	localparam logic [7:0] CMD_MARGIN_LOW    = 8'h26;
	localparam logic [7:0] CMD_VIN_ON        = 8'h35;
	localparam logic [7:0] CMD_VIN_OFF       = 8'h36;
	localparam logic [7:0] CMD_TURN_ON_DELAY_TIME     = 8'h60;
	localparam logic [7:0] CMD_OUTPUT_RISE_TIME      = 8'h61;
	localparam logic [7:0] CMD_READ_VIN      = 8'h88;
	localparam logic [7:0] CMD_READ_VOUT     = 8'h8b;
	localparam logic [7:0] CMD_READ_IOUT     = 8'h8c;
	localparam logic [7:0] CMD_WRITE_PROTECT = 8'hd0;
	localparam logic [7:0] CMD_VOUT_OFS      = 8'hd4;
	localparam logic [7:0] CMD_VIN_OFS       = 8'hd5;
	localparam logic [7:0] CMD_VIN_GAIN      = 8'hd6;
	localparam logic [7:0] CMD_IOUT_OFS      = 8'hd7;
	localparam logic [7:0] CMD_IOUT_GAIN     = 8'hd8;

	// command data lengths
	localparam logic [1:0] LEN_NONE    = 2'h0;
	localparam logic [1:0] LEN_BYTE    = 2'h1;
	localparam logic [1:0] LEN_WORD    = 2'h2;
	localparam logic [1:0] LEN_SEND    = 2'h3;

	// field positions and codes
	localparam int         OP_ON_BIT      = 7;
	localparam int         CFG_CMD_BIT    = 3;
	localparam int         WP_ON_BIT      = 0;
	localparam logic [7:0] CFG_FIXED_ONES = 8'hf7;
	localparam logic [3:0] MARGIN_LOW_SEL  = 4'h6;
	localparam logic [3:0] MARGIN_HIGH_SEL = 4'ha;
	localparam logic [4:0] EXP_M3          = 5'h1d;
	localparam logic [4:0] EXP_M1          = 5'h1f;
	localparam int         GAIN_SHIFT      = 13;
	localparam logic [9:0] MANT_MAX        = 10'h3ff;

	// limits: 8.10 V and 13.20 V in 2^-12 V, 10/15/500 ms in 0.5 ms, 20 A in 0.125 A
	localparam logic [15:0] VOUT_MIN       = 16'h819a;
	localparam logic [15:0] VOUT_MAX       = 16'hd333;
	localparam logic [10:0] DELAY_MIN      = 11'h014;
	localparam logic [10:0] RISE_MIN       = 11'h01e;
	localparam logic [10:0] TIME_MAX       = 11'h3e8;
	localparam logic [9:0]  IOUT_BLANK     = 10'h0a0;

	// reset values
	localparam logic [7:0]  OP_RESET       = 8'h80;
	localparam logic [7:0]  CFG_RESET      = 8'hff;
	localparam logic [7:0]  WP_RESET       = 8'h01;
	localparam logic [15:0] VOUT_RESET     = 16'hc000;
	localparam logic [15:0] MHIGH_RESET    = 16'hc800;
	localparam logic [15:0] MLOW_RESET     = 16'hb800;
	localparam logic [15:0] VIN_ON_RESET   = 16'he930;
	localparam logic [15:0] VIN_OFF_RESET  = 16'he920;
	localparam logic [15:0] DELAY_RESET    = 16'hf814;
	localparam logic [15:0] RISE_RESET     = 16'hf81e;
	localparam logic [15:0] GAIN_UNITY     = 16'h2000;
	localparam logic [15:0] LIN_ZERO_M3    = 16'he800;
	localparam logic [6:0]  ADDR_DEFAULT   = 7'h60;

endpackage : pmbus_handler_pkg

/* pmbus_command_data_handler.sv */
// command-data handler behind the module's management bus slave pins
`timescale 1ns/10ps
module pmbus_command_data_handler
	import pmbus_handler_pkg::*;
#(
	parameter logic [6:0]  DEVICE_ADDRESS = ADDR_DEFAULT,
	parameter logic        ON_OFF_NEG     = 1'b1,
	parameter logic [15:0] VOUT_CAL_OFS   = 16'h0000,
	parameter logic [15:0] VIN_CAL_GAIN   = GAIN_UNITY,
	parameter logic [15:0] VIN_CAL_OFS    = LIN_ZERO_M3,
	parameter logic [15:0] IOUT_CAL_GAIN  = GAIN_UNITY,
	parameter logic [15:0] IOUT_CAL_OFS   = LIN_ZERO_M3
)
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        clock_enable,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        on_off_pin,
	input  wire logic [15:0] raw_vout,
	input  wire logic [15:0] raw_vin,
	input  wire logic [15:0] raw_iout,
	output logic             output_on,
	output logic [15:0]      vout_target,
	output logic [15:0]      vin_on_level,
	output logic [15:0]      vin_off_level,
	output logic [15:0]      delay_setting,
	output logic [15:0]      rise_setting,
	output logic             store_strobe
);

	typedef enum logic [2:0] {
		LINK_IDLE  = 3'b000,
		LINK_ADDR  = 3'b001,
		LINK_CMD   = 3'b010,
		LINK_WDATA = 3'b011,
		LINK_ACK   = 3'b100,
		LINK_RDATA = 3'b101,
		LINK_MACK  = 3'b110
	} link_state_t;

	// packet error code, polynomial x^8+x^2+x+1
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
			r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction : crc8

	// data length of each supported command, none for unknown codes
	function automatic logic [1:0] cmd_length(input logic [7:0] c);
		case (c)
			CMD_OPERATION, CMD_ON_OFF_CONFIG, CMD_WRITE_PROTECT: return LEN_BYTE;
			CMD_STORE_ALL: return LEN_SEND;
			CMD_VOUT_SET, CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_VIN_ON, CMD_VIN_OFF,
			CMD_TURN_ON_DELAY_TIME, CMD_OUTPUT_RISE_TIME, CMD_READ_VIN, CMD_READ_VOUT, CMD_READ_IOUT,
			CMD_VOUT_OFS, CMD_VIN_OFS, CMD_VIN_GAIN, CMD_IOUT_OFS, CMD_IOUT_GAIN:
				return LEN_WORD;
			default: return LEN_NONE;
		endcase
	endfunction : cmd_length

	// raw times gain over 8192 plus linear offset, clamped to a positive mantissa
	function automatic logic [9:0] gain_offset(input logic [15:0] raw, input logic [15:0] gain,
		input logic [15:0] ofs);
		logic [31:0]        prod;
		logic signed [20:0] sum;
		prod = raw * gain;
		sum  = $signed({2'b00, prod[31:GAIN_SHIFT]}) + $signed({{10{ofs[10]}}, ofs[10:0]});
		if (sum < 0)
			return 10'h000;
		else if (sum > $signed({11'h000, MANT_MAX}))
			return MANT_MAX;
		else
			return sum[9:0];
	endfunction : gain_offset

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic scl_meta, scl_s, scl_q, sda_meta, sda_s, sda_q, pin_meta, pin_s;

	// two flops per pin; only the second stage, and for scl and sda its delayed copy, feed logic
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			{scl_meta, scl_s, scl_q} <= 3'h7;
			{sda_meta, sda_s, sda_q} <= 3'h7;
			{pin_meta, pin_s}        <= 2'h0;
		end
		else if (clock_enable)
		begin
			{scl_meta, scl_s, scl_q} <= {scl_in, scl_meta, scl_s};
			{sda_meta, sda_s, sda_q} <= {sda_in, sda_meta, sda_s};
			{pin_meta, pin_s}        <= {on_off_pin, pin_meta};
		end

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
	wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
	wire pin_on    = pin_s ^ ON_OFF_NEG;

	////////////////////////////////////////////////////////////////////////////////
	// settings and readings storage

	logic [7:0]  operation, on_off_cfg, write_protect;
	logic [15:0] vout_set, margin_high, margin_low;
	logic [15:0] vout_reading, vin_reading, iout_reading;
	logic        commit_pulse;
	logic [7:0]  commit_cmd, command;
	logic [15:0] commit_word;
	logic [15:0] read_word;
	wire         wp_active = write_protect[WP_ON_BIT];

	// readback word selected by the latched command
	always_comb
	begin
		read_word = 16'h0000;
		case (command)
			CMD_OPERATION:     read_word = {8'h00, operation};
			CMD_ON_OFF_CONFIG: read_word = {8'h00, on_off_cfg};
			CMD_WRITE_PROTECT: read_word = {8'h00, write_protect};
			CMD_VOUT_SET:      read_word = vout_set;
			CMD_MARGIN_HIGH:   read_word = margin_high;
			CMD_MARGIN_LOW:    read_word = margin_low;
			CMD_VIN_ON:        read_word = vin_on_level;
			CMD_VIN_OFF:       read_word = vin_off_level;
			CMD_TURN_ON_DELAY_TIME:     read_word = delay_setting;
			CMD_OUTPUT_RISE_TIME:      read_word = rise_setting;
			CMD_READ_VOUT:     read_word = vout_reading;
			CMD_READ_VIN:      read_word = vin_reading;
			CMD_READ_IOUT:     read_word = iout_reading;
			CMD_VOUT_OFS:      read_word = VOUT_CAL_OFS;     // [RULE_17]
			CMD_VIN_OFS:       read_word = VIN_CAL_OFS;
			CMD_VIN_GAIN:      read_word = VIN_CAL_GAIN;
			CMD_IOUT_OFS:      read_word = IOUT_CAL_OFS;
			CMD_IOUT_GAIN:     read_word = IOUT_CAL_GAIN;
			default:           read_word = 16'h0000;
		endcase
	end

	// corrected readings, refreshed every cycle; a read snapshots them at the read address
	logic signed [17:0] vout_sum;
	assign vout_sum = $signed({2'b00, raw_vout}) + $signed({{2{VOUT_CAL_OFS[15]}}, VOUT_CAL_OFS});
	logic [9:0] iout_mant;
	assign iout_mant = gain_offset(raw_iout, IOUT_CAL_GAIN, IOUT_CAL_OFS);   // [RULE_22]

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			vout_reading <= 16'h0000;
			vin_reading  <= LIN_ZERO_M3;
			iout_reading <= LIN_ZERO_M3;
		end
		else if (clock_enable)
		begin
			// unsigned result, clamped so the offset cannot wrap it [RULE_16] [RULE_17]
			vout_reading <= vout_sum[17] ? 16'h0000 : vout_sum[16] ? 16'hffff : vout_sum[15:0];
			vin_reading  <= {EXP_M3, 1'b0, gain_offset(raw_vin, VIN_CAL_GAIN, VIN_CAL_OFS)}; // [RULE_18] [RULE_19]
			// sinking current or a reading under the blanking level shows zero [RULE_20] [RULE_21]
			if (raw_iout[15] || iout_mant < IOUT_BLANK)
				iout_reading <= {EXP_M3, 11'h000};
			else
				iout_reading <= {EXP_M3, 1'b0, iout_mant};
		end

	// setting writes: write protection gates every change but write_protect and the store strobe; range checks gate vout_set and times, format checks vin levels
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			operation     <= OP_RESET;                       // [RULE_06]
			on_off_cfg    <= CFG_RESET;
			write_protect <= WP_RESET;                       // [RULE_04]
			vout_set      <= VOUT_RESET;
			margin_high   <= MHIGH_RESET;
			margin_low    <= MLOW_RESET;
			vin_on_level  <= VIN_ON_RESET;
			vin_off_level <= VIN_OFF_RESET;
			delay_setting <= DELAY_RESET;
			rise_setting  <= RISE_RESET;
			store_strobe  <= 1'b0;
		end
		else if (clock_enable)
		begin
			store_strobe <= 1'b0;
			if (commit_pulse)
				case (commit_cmd)
					CMD_WRITE_PROTECT: write_protect <= commit_word[7:0]; // [RULE_04]
					CMD_STORE_ALL:     store_strobe <= 1'b1;              // [RULE_05]
					CMD_OPERATION:     if (!wp_active) operation <= commit_word[7:0]; // [RULE_25]
					CMD_ON_OFF_CONFIG:
						if (!wp_active)
							on_off_cfg <= commit_word[7:0] | CFG_FIXED_ONES; // [RULE_08]
					CMD_VOUT_SET:
						if (!wp_active && commit_word >= VOUT_MIN && commit_word <= VOUT_MAX)
							vout_set <= commit_word;                   // [RULE_14] [RULE_01]
					CMD_MARGIN_HIGH:   if (!wp_active) margin_high <= commit_word;
					CMD_MARGIN_LOW:    if (!wp_active) margin_low <= commit_word;
					CMD_VIN_ON:
						if (!wp_active && commit_word[15:10] == {EXP_M3, 1'b0})
							vin_on_level <= commit_word;               // [RULE_10] [RULE_02]
					CMD_VIN_OFF:
						if (!wp_active && commit_word[15:10] == {EXP_M3, 1'b0})
							vin_off_level <= commit_word;              // [RULE_10]
					CMD_TURN_ON_DELAY_TIME:
						if (!wp_active && commit_word[15:11] == EXP_M1 &&
							commit_word[10:0] >= DELAY_MIN && commit_word[10:0] <= TIME_MAX)
							delay_setting <= commit_word;              // [RULE_12]
					CMD_OUTPUT_RISE_TIME:
						if (!wp_active && commit_word[15:11] == EXP_M1 &&
							commit_word[10:0] >= RISE_MIN && commit_word[10:0] <= TIME_MAX)
							rise_setting <= commit_word;               // [RULE_13]
					default: ;
				endcase
		end

	// output gating and margin selection, registered straight to the ports
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			output_on   <= 1'b0;
			vout_target <= VOUT_RESET;
		end
		else if (clock_enable)
		begin
			output_on <= pin_on && (!on_off_cfg[CFG_CMD_BIT] || operation[OP_ON_BIT]); // [RULE_07] [RULE_09]
			if (operation[5:2] == MARGIN_LOW_SEL)
				vout_target <= margin_low;                     // [RULE_15]
			else if (operation[5:2] == MARGIN_HIGH_SEL)
				vout_target <= margin_high;
			else
				vout_target <= vout_set;
		end

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: byte engine with ack, packet error code and write commit

	link_state_t link_state, after_ack;
	logic [3:0]  bit_cnt;
	logic [7:0]  shift_in, tx_byte, crc;
	logic [15:0] tx_word, wbuf;
	logic [1:0]  tx_index, rx_count;
	logic        cmd_valid, write_open, mack_seen;
	logic [7:0]  next_tx_byte;
	wire  [1:0]  cur_len = cmd_length(command);
	wire  [1:0]  exp_cnt = (cur_len == LEN_SEND) ? 2'h0 : cur_len;
	wire         tx_is_data = tx_index < exp_cnt;

	// data bytes low first, then the error code [RULE_03] [RULE_23]
	always_comb
		next_tx_byte = !tx_is_data ? crc : (tx_index == 2'h0) ? tx_word[7:0] : tx_word[15:8];

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			link_state   <= LINK_IDLE;
			after_ack    <= LINK_IDLE;
			bit_cnt      <= 4'h0;
			shift_in     <= 8'h00;
			tx_byte      <= 8'h00;
			tx_word      <= 16'h0000;
			tx_index     <= 2'h0;
			command      <= 8'h00;
			crc          <= 8'h00;
			wbuf         <= 16'h0000;
			rx_count     <= 2'h0;
			cmd_valid    <= 1'b0;
			write_open   <= 1'b0;
			mack_seen    <= 1'b0;
			sda_oe       <= 1'b0;
			commit_pulse <= 1'b0;
			commit_cmd   <= 8'h00;
			commit_word  <= 16'h0000;
		end
		else if (clock_enable)
		begin
			commit_pulse <= 1'b0;
			if (bus_start)
			begin
				link_state <= LINK_ADDR;
				bit_cnt    <= 4'h0;
				sda_oe     <= 1'b0;
			end
			else if (bus_stop)
			begin
				// commit with exact length, or length plus a matching error code [RULE_23]
				if (write_open && (rx_count == exp_cnt || (rx_count == exp_cnt + 2'h1 && crc == 8'h00)))
				begin
					commit_pulse <= 1'b1;
					commit_cmd   <= command;
					commit_word  <= wbuf;
				end
				write_open <= 1'b0;
				link_state <= LINK_IDLE;
				sda_oe     <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (link_state == LINK_MACK)
					mack_seen <= ~sda_s;
				else if (link_state inside {LINK_ADDR, LINK_CMD, LINK_WDATA})
				begin
					shift_in <= {shift_in[6:0], sda_s};
					bit_cnt  <= bit_cnt + 4'h1;
				end
			end
			else if (scl_fall)
				case (link_state)
					LINK_ADDR, LINK_CMD, LINK_WDATA:
						if (bit_cnt == 4'h8)
						begin
							bit_cnt    <= 4'h0;
							link_state <= LINK_ACK;
							sda_oe     <= 1'b1;
							if (link_state == LINK_ADDR)
							begin
								if (shift_in[7:1] != DEVICE_ADDRESS)
								begin
									link_state <= LINK_IDLE;
									sda_oe     <= 1'b0;
								end
								else if (!shift_in[0])
								begin
									crc        <= crc8(8'h00, shift_in);
									cmd_valid  <= 1'b0;
									write_open <= 1'b0;
									after_ack  <= LINK_CMD;
								end
								else if (cmd_valid && (cur_len == LEN_BYTE || cur_len == LEN_WORD))
								begin
									crc        <= crc8(crc, shift_in);
									tx_word    <= read_word;
									tx_index   <= 2'h0;
									write_open <= 1'b0;
									after_ack  <= LINK_RDATA;
								end
								else
								begin
									link_state <= LINK_IDLE;
									sda_oe     <= 1'b0;
								end
							end
							else if (link_state == LINK_CMD)
							begin
								if (cmd_length(shift_in) == LEN_NONE)
								begin
									link_state <= LINK_IDLE;
									sda_oe     <= 1'b0;
								end
								else
								begin
									crc        <= crc8(crc, shift_in);
									command    <= shift_in;
									cmd_valid  <= 1'b1;
									write_open <= 1'b1;
									rx_count   <= 2'h0;
									after_ack  <= LINK_WDATA;
								end
							end
							else if (rx_count == 2'h3)
							begin
								link_state <= LINK_IDLE;
								sda_oe     <= 1'b0;
								write_open <= 1'b0;
							end
							else
							begin
								crc      <= crc8(crc, shift_in);
								rx_count <= rx_count + 2'h1;
								if (rx_count == 2'h0)
									wbuf[7:0] <= shift_in;             // [RULE_03]
								else if (rx_count == 2'h1)
									wbuf[15:8] <= shift_in;
								after_ack <= LINK_WDATA;
							end
						end
					LINK_ACK, LINK_MACK:
						if (link_state == LINK_MACK && !mack_seen)
						begin
							link_state <= LINK_IDLE;
							sda_oe     <= 1'b0;
						end
						else if (after_ack == LINK_RDATA || link_state == LINK_MACK)
						begin
							link_state <= LINK_RDATA;
							tx_byte    <= next_tx_byte;
							sda_oe     <= ~next_tx_byte[7];
							bit_cnt    <= 4'h1;
							tx_index   <= (tx_index == 2'h3) ? tx_index : tx_index + 2'h1;
							if (tx_is_data)
								crc <= crc8(crc, next_tx_byte);
						end
						else
						begin
							link_state <= after_ack;
							sda_oe     <= 1'b0;
						end
					LINK_RDATA:
						if (bit_cnt == 4'h8)
						begin
							sda_oe     <= 1'b0;
							link_state <= LINK_MACK;
						end
						else
						begin
							tx_byte <= {tx_byte[6:0], 1'b0};
							sda_oe  <= ~tx_byte[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					default: ;
				endcase
		end

	// the slave never stretches the clock, so no low period can near the limit
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;                                   // [RULE_24]
			sda_out <= 1'b0;
		end
		else if (clock_enable)
		begin
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_out <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	no_clock_stretch_a: assert property (!scl_oe) // [RULE_24]
		else $error("clock line driven by slave");
	cfg_fixed_ones_a: assert property ((on_off_cfg | 8'h08) == 8'hff) // [RULE_08]
		else $error("on/off config fixed bits not one");
	vout_range_a: assert property (vout_set >= VOUT_MIN && vout_set <= VOUT_MAX) // [RULE_14]
		else $error("output setpoint out of range");
	delay_range_a: assert property (delay_setting[15:11] == EXP_M1 && delay_setting[10:0] >= 11'h014 // [RULE_12]
		&& delay_setting[10:0] <= 11'h3e8)
		else $error("turn-on delay out of range");
	output_gate_a: assert property (clock_enable && $past(clock_enable) && // [RULE_09]
		!$past(reset) |-> output_on == $past(pin_on && (!on_off_cfg[3] || operation[7])))
		else $error("output enable does not follow pin and operation");
	iout_sink_zero_a: assert property (clock_enable && $past(clock_enable) && $past(raw_iout[15]) // [RULE_21]
		|-> iout_reading[10:0] == 11'h000)
		else $error("sinking current not reported as zero");
	protect_hold_a: assert property (wp_active && commit_pulse && commit_cmd != CMD_WRITE_PROTECT // [RULE_25]
		|=> $stable(vout_set) && $stable(operation) && $stable(margin_high))
		else $error("setting changed under write protection");
	store_pulse_a: assert property ($rose(store_strobe) |-> $past(commit_pulse && commit_cmd == 8'h11) // [RULE_05]
		##1 !store_strobe)
		else $error("store strobe not a single pulse after store command");
	margin_high_a: assert property (clock_enable && $past(clock_enable) && $past(operation[5:2] == 4'ha) // [RULE_15]
		|-> vout_target == $past(margin_high))
		else $error("margin high not selected");

endmodule : pmbus_command_data_handler

/* pmbus_host_model.sv */
// bus master model: drives the bus clock and releases or pulls the data line
`timescale 1ns/10ps
module pmbus_host_model
(
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_h
);
	// lines idle released; the pull-up holds them high
	initial
	begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task d(input int n);
		repeat (n) @(posedge clock);
	endtask : d
	// one bit: low 10 clocks, high 6 (80 ns); sampled mid-high, device never stretches
	task xb(input logic b, output logic r);
		d(5);
		sda_h <= b;
		d(5);
		scl <= 1'b1;
		d(3);
		r = sda;
		d(3);
		scl <= 1'b0;
	endtask : xb
	// start is step(1,1,0,0), stop is step(0,1,1,1)
	task step(input logic s1, input logic c1, input logic s2, input logic c2);
		d(5);
		sda_h <= s1;
		d(5);
		scl <= c1;
		d(5);
		sda_h <= s2;
		d(5);
		scl <= c2;
	endtask : step
	// byte out msb first, then the ack bit m; a is the sampled ack level
	task byte_x(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			xb(w[i], r[i]);
		xb(m, a);
	endtask : byte_x
endmodule : pmbus_host_model

/* pmbus_command_data_handler_tb.sv */
// self-checking bench for the command-data handler
`timescale 1ns/10ps
module pmbus_command_data_handler_tb;
	import pmbus_handler_pkg::*;
	logic        clock, reset, clock_enable, on_off_pin, output_on, store_strobe;
	logic        scl, sda_h, scl_out, scl_oe, sda_out, sda_oe;
	logic [15:0] raw_vout, raw_vin, raw_iout, vout_target, vin_on_level, vin_off_level;
	logic [15:0] delay_setting, rise_setting, v;
	int          fails, n_checks, strobes;
	// open-drain wires: low if any party pulls
	wire scl_in = scl & ~(scl_oe & ~scl_out);
	wire sda_in = sda_h & ~(sda_oe & ~sda_out);
	pmbus_host_model host (.clock(clock), .sda(sda_in), .scl(scl), .sda_h(sda_h));
	pmbus_command_data_handler DUT (.clock(clock), .reset(reset), .clock_enable(clock_enable),
		.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .on_off_pin(on_off_pin), .raw_vout(raw_vout),
		.raw_vin(raw_vin), .raw_iout(raw_iout), .output_on(output_on),
		.vout_target(vout_target), .vin_on_level(vin_on_level),
		.vin_off_level(vin_off_level), .delay_setting(delay_setting),
		.rise_setting(rise_setting), .store_strobe(store_strobe));
	always @(posedge clock)
		if (store_strobe === 1'b1)
			strobes++;
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++)
			x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
		return x;
	endfunction : crc
	////////////////////////////////////////////////////////////////////////////////////////
	// write n data bytes low first; pec 1 appends a bad check byte, 2 a good one
	task wr(input logic [7:0] c, input int n, input logic [15:0] w, input logic [1:0] pec);
		logic [7:0] q[$];
		logic [7:0] p, r;
		logic       a;
		q = {8'hc0, c, w[7:0], w[15:8]};
		q = q[0:n+1];
		p = 8'h00;
		host.step(1, 1, 0, 0);
		foreach (q[i])
		begin
			p = crc(p, q[i]);
			host.byte_x(q[i], 1'b1, r, a);
		end
		if (pec != 2'h0)
			host.byte_x(p ^ {7'h0, pec[0]}, 1'b1, r, a);
		host.step(0, 1, 1, 1);
		repeat (6) @(posedge clock);
	endtask : wr
	// read n bytes, then the check byte, which is verified here
	task rd(input logic [7:0] c, input int n, output logic [15:0] w);
		logic [7:0] p, r, b;
		logic       a;
		host.step(1, 1, 0, 0);
		host.byte_x(8'hc0, 1'b1, r, a);
		host.byte_x(c, 1'b1, r, a);
		host.step(1, 1, 0, 0);
		host.byte_x(8'hc1, 1'b1, r, a);
		p = crc(crc(crc(8'h00, 8'hc0), c), 8'hc1);
		w = 16'h0000;
		for (int i = 0; i < n; i++)
		begin
			host.byte_x(8'hff, 1'b0, b, a);
			w[8*i +: 8] = b;
			p = crc(p, b);
		end
		host.byte_x(8'hff, 1'b1, b, a);
		host.step(0, 1, 1, 1);
		chk("pec", {8'h00, p}, {8'h00, b});
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		chk("vout", VOUT_RESET, vout_target);
		chk("vin_on", VIN_ON_RESET, vin_on_level);
		chk("vin_off", VIN_OFF_RESET, vin_off_level);
		chk("delay", DELAY_RESET, delay_setting);
		chk("rise", RISE_RESET, rise_setting);
		chk("on", 16'h0001, {15'h0, output_on});
		rd(CMD_OPERATION, 1, v);
		chk("op", 16'h0080, v);
		rd(CMD_ON_OFF_CONFIG, 1, v);
		chk("cfg", 16'h00ff, v);
		rd(CMD_WRITE_PROTECT, 1, v);
		chk("wp", 16'h0001, v);
		$display("t_reset done");
	endtask : t_reset
	task t_protect;
		wr(CMD_VOUT_SET, 2, 16'hc800, 0);
		chk("vout", VOUT_RESET, vout_target);
		wr(CMD_WRITE_PROTECT, 1, 16'h0000, 0);
		wr(CMD_VOUT_SET, 2, 16'hc800, 0);
		chk("vout", 16'hc800, vout_target);
		wr(CMD_VOUT_SET, 2, 16'h8199, 0);
		chk("vout", 16'hc800, vout_target);
		wr(CMD_VOUT_SET, 2, 16'hd333, 2);
		chk("vout", 16'hd333, vout_target);
		wr(CMD_VOUT_SET, 2, 16'hc000, 1);
		chk("vout", 16'hd333, vout_target);
		strobes = 0;
		wr(CMD_STORE_ALL, 0, 16'h0000, 0);
		chk("store", 16'h0001, strobes[15:0]);
		$display("t_protect done");
	endtask : t_protect
	task t_onoff;
		wr(CMD_OPERATION, 1, 16'h0000, 0);
		chk("on", 16'h0000, {15'h0, output_on});
		wr(CMD_ON_OFF_CONFIG, 1, 16'h0000, 0);
		chk("on", 16'h0001, {15'h0, output_on});
		rd(CMD_ON_OFF_CONFIG, 1, v);
		chk("cfg", 16'h00f7, v);
		on_off_pin <= 1'b1;
		repeat (5) @(posedge clock);
		chk("on", 16'h0000, {15'h0, output_on});
		on_off_pin <= 1'b0;
		wr(CMD_ON_OFF_CONFIG, 1, 16'h00ff, 0);
		wr(CMD_MARGIN_LOW, 2, 16'hb000, 0);
		wr(CMD_OPERATION, 1, 16'h0098, 0);
		chk("on", 16'h0001, {15'h0, output_on});
		chk("mlow", 16'hb000, vout_target);
		wr(CMD_OPERATION, 1, 16'h00a8, 0);
		chk("mhigh", MHIGH_RESET, vout_target);
		wr(CMD_OPERATION, 1, 16'h008c, 0);
		chk("nominal", 16'hd333, vout_target);
		$display("t_onoff done");
	endtask : t_onoff
	task t_times;
		wr(CMD_TURN_ON_DELAY_TIME, 2, 16'hf813, 0);
		chk("delay", DELAY_RESET, delay_setting);
		wr(CMD_TURN_ON_DELAY_TIME, 2, 16'hfbe8, 0);
		chk("delay", 16'hfbe8, delay_setting);
		wr(CMD_OUTPUT_RISE_TIME, 2, 16'hf81d, 0);
		chk("rise", RISE_RESET, rise_setting);
		wr(CMD_OUTPUT_RISE_TIME, 2, 16'hf81f, 0);
		chk("rise", 16'hf81f, rise_setting);
		wr(CMD_VIN_ON, 2, 16'he940, 0);
		chk("vin_on", 16'he940, vin_on_level);
		wr(CMD_VIN_OFF, 2, 16'hec00, 0);
		chk("vin_off", VIN_OFF_RESET, vin_off_level);
		$display("t_times done");
	endtask : t_times
	task t_read;
		raw_vout <= 16'h1234;
		raw_vin <= 16'h0180;
		raw_iout <= 16'h009f;
		rd(CMD_READ_VOUT, 2, v);
		chk("vout_rd", 16'h1234, v);
		rd(CMD_READ_VIN, 2, v);
		chk("vin_rd", 16'he980, v);
		rd(CMD_READ_IOUT, 2, v);
		chk("iout_rd", LIN_ZERO_M3, v);
		raw_iout <= 16'h00a0;
		rd(CMD_READ_IOUT, 2, v);
		chk("iout_rd", 16'he8a0, v);
		raw_iout <= 16'h8000;
		rd(CMD_READ_IOUT, 2, v);
		chk("iout_rd", LIN_ZERO_M3, v);
		rd(CMD_VIN_GAIN, 2, v);
		chk("gain", GAIN_UNITY, v);
		$display("t_read done");
	endtask : t_read
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// a run needs about 100 us; four times that means a hang
	initial
	begin
		#400000;
		fails++;
		wrap_up;
	end
	initial
	begin
		reset = 1'b1;
		clock_enable = 1'b1;
		on_off_pin = 1'b0;
		raw_vout = 16'h0000;
		raw_vin = 16'h0000;
		raw_iout = 16'h0000;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		repeat (6) @(posedge clock);
		t_reset;
		t_protect;
		t_onoff;
		t_times;
		t_read;
		wrap_up;
	end
endmodule : pmbus_command_data_handler_tb
